// File: rtl/deb_pkg.sv
// Shared constants, register map and carrier types of the external bus controller
package deb_pkg;

    // Address bus and memory map
    localparam int               ADDR_W        = 20;
    localparam int               PAGE_W        = 4;
    localparam int               LOW_ADDR_W    = 16;
    localparam logic [ADDR_W-1:0] RESET_VECTOR = 20'h0ff80;
    localparam logic [PAGE_W-1:0] ROM_PAGE     = 4'hf;
    localparam logic [PAGE_W-1:0] EXT_PAGE_0   = 4'h0;
    localparam int               ROM_PAGE_LSB  = 12;

    // Register byte offsets, decoded on the low address bits
    localparam int              REG_AW     = 8;
    localparam logic [REG_AW-1:0] OFS_MODE   = 8'h00;
    localparam logic [REG_AW-1:0] OFS_STAT1  = 8'h04;
    localparam logic [REG_AW-1:0] OFS_FLAG   = 8'h08;
    localparam logic [REG_AW-1:0] OFS_WAIT   = 8'h0c;
    localparam logic [REG_AW-1:0] OFS_AADDR  = 8'h10;
    localparam logic [REG_AW-1:0] OFS_ACMD   = 8'h14;
    localparam logic [REG_AW-1:0] OFS_STATUS = 8'h18;
    localparam logic [REG_AW-1:0] OFS_BRCFG  = 8'h1c;

    // Field positions
    localparam int MODE_ROM_OFF_BIT = 0;
    localparam int FLAG_SET_BIT     = 0;
    localparam int FLAG_CLR_BIT     = 1;
    localparam int WAIT_MEM_LSB     = 0;
    localparam int WAIT_IO_LSB      = 4;
    localparam int CMD_SPACE_LSB    = 0;
    localparam int CMD_WR_BIT       = 2;
    localparam int CMD_FETCH_BIT    = 3;
    localparam int BRCFG_XC_BIT     = 0;
    localparam int STAT1_W          = 16;
    localparam int STS_BUSY_BIT     = 0;
    localparam int STS_HOLD_BIT     = 1;
    localparam int STS_BRANCH_BIT   = 2;
    localparam int STS_ROM_IN_BIT   = 3;
    localparam int STS_BOOT_BIT     = 4;
    localparam int STS_XF_BIT       = 5;
    localparam int STS_PEND_BIT     = 6;

    // Reset values
    localparam logic [STAT1_W-1:0] STAT1_RST = 16'h0000;
    localparam logic [ADDR_W-1:0]  AADDR_RST = 20'h00000;

    // AHB-Lite encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic       HRESP_OKAY = 1'h0;

    typedef enum logic [1:0] {
        SP_DATA = 2'h0,
        SP_PROG = 2'h1,
        SP_IO   = 2'h2
    } deb_space_t;

    typedef struct packed {
        deb_space_t         space;
        logic               wr;
        logic               fetch;
        logic [ADDR_W-1:0]  addr;
    } deb_acc_t;

    // Control pins; used for both levels and output enables
    typedef struct packed {
        logic data_space_select_n;
        logic program_space_select_n;
        logic io_space_select_n;
        logic memory_strobe_n;
        logic io_device_strobe_n;
        logic rw;
        logic wait_state_done;
        logic instr_fetch_flag_n;
        logic external_flag_output;
        logic bus_grant_ack;
    } deb_pins_t;

    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_STRB  = 5'b00010,
        S_SWAIT = 5'b00100,
        S_RDY   = 5'b01000,
        S_HOLD  = 5'b10000
    } deb_state_t;

endpackage

// File: rtl/deb_ext_bus_ctrl.sv
// External memory/I-O bus control of the DSP, with an AHB-Lite register port
`timescale 1ns/10ps
module deb_ext_bus_ctrl
    import deb_pkg::*;
#(
    parameter int WAIT_W = 3
) (
    // Clock and reset
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // AHB-Lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic [31:0]             hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    // Device pins, inputs
    input  wire logic               cpu_reset_n,
    input  wire logic               rom_map_select,
    input  wire logic               branch_condition_input,
    input  wire logic               ready,
    input  wire logic               hold_req_n,
    input  wire logic               output_float_n,
    // Pipeline phase strobes from the core
    input  wire logic               pipe_decode_stb,
    input  wire logic               pipe_read_stb,
    // Device pins, outputs with enables
    output deb_pins_t               pin_o,
    output deb_pins_t               pin_oe,
    output logic [ADDR_W-1:0]       ext_addr,
    output logic                    ext_addr_oe,
    // Core-side status
    output logic                    branch_taken,
    output logic                    rom_in_program_space
);

    localparam logic [WAIT_W-1:0] MIN_READY_WAITS = WAIT_W'(2);
    localparam logic [WAIT_W-1:0] ONE_WAIT        = WAIT_W'(1);
    localparam logic [WAIT_W-1:0] NO_WAIT         = '0;
    function automatic logic rom_hit(input deb_acc_t a, input logic rom_off);
        rom_hit = (a.space == SP_PROG) && !rom_off
               && (a.addr[ADDR_W-1:LOW_ADDR_W] == EXT_PAGE_0)
               && (a.addr[LOW_ADDR_W-1:ROM_PAGE_LSB] == ROM_PAGE);
    endfunction
    function automatic logic [WAIT_W-1:0] waits_for(input deb_space_t sp,
                                                    input logic [WAIT_W-1:0] mem_w,
                                                    input logic [WAIT_W-1:0] io_w);
        waits_for = (sp == SP_IO) ? io_w : mem_w;
    endfunction
    // AHB-Lite front end
    logic                   wvalid_r;
    logic [REG_AW-1:0]      waddr_r;
    logic [31:0]            rdata_r;
    // Software-visible state
    logic                   rom_off_r;
    logic [STAT1_W-1:0]     stat1_r;
    logic                   xf_r;
    logic [WAIT_W-1:0]      wait_mem_r;
    logic [WAIT_W-1:0]      wait_io_r;
    logic [ADDR_W-1:0]      aaddr_r;
    deb_acc_t               cmd_r;
    logic                   pend_r;
    logic                   boot_pend_r;
    logic                   xc_sel_r;
    logic                   cond_dec_r;
    logic                   cond_rd_r;
    // Access sequencer
    deb_state_t             st_r;
    deb_state_t             st_nxt;
    deb_acc_t               acc_r;
    logic                   ext_r;
    logic [WAIT_W-1:0]      wtot_r;
    logic [WAIT_W-1:0]      widx_r;
    // Address phase: only whole-word transfers are taken
    wire                    take    = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
    wire [REG_AW-1:0]       aofs    = haddr[REG_AW-1:0];
    wire                    wr_mode = wvalid_r && (waddr_r == OFS_MODE);
    wire                    wr_st1  = wvalid_r && (waddr_r == OFS_STAT1);
    wire                    wr_flag = wvalid_r && (waddr_r == OFS_FLAG);
    wire                    wr_wait = wvalid_r && (waddr_r == OFS_WAIT);
    wire                    wr_aadr = wvalid_r && (waddr_r == OFS_AADDR);
    wire                    wr_acmd = wvalid_r && (waddr_r == OFS_ACMD) && !pend_r;
    wire                    wr_brcf = wvalid_r && (waddr_r == OFS_BRCFG);
    // Sequencer decode
    wire                    busy       = (st_r == S_STRB) || (st_r == S_SWAIT)
                                      || (st_r == S_RDY);
    wire                    active_ext = busy && ext_r;
    wire                    in_hold    = (st_r == S_HOLD);
    wire                    go         = cpu_reset_n && (boot_pend_r || pend_r);
    wire                    need_rdy   = (wtot_r >= MIN_READY_WAITS);
    wire                    last_wait  = (widx_r == wtot_r);
    wire                    msc_low    = (st_r == S_SWAIT) && need_rdy && !last_wait;
    wire deb_acc_t          boot_acc   = '{space: SP_PROG, wr: 1'b0, fetch: 1'b1,
                                           addr: RESET_VECTOR};
    wire deb_acc_t          next_acc   = boot_pend_r ? boot_acc : cmd_r;
    wire [WAIT_W-1:0]       next_waits = waits_for(next_acc.space, wait_mem_r, wait_io_r);
    wire                    start      = (st_r == S_IDLE) && (st_nxt == S_STRB);
    // Branch condition: low input means true
    wire                    cond_sel   = xc_sel_r ? cond_dec_r : cond_rd_r;
    // Register read mux
    wire [31:0] sts_word = {25'h0000000, pend_r, xf_r, boot_pend_r,
                            !rom_off_r, branch_taken, in_hold, busy};
    wire [31:0] rd_mux =
        (aofs == OFS_MODE)   ? {31'h00000000, rom_off_r} :
        (aofs == OFS_STAT1)  ? {16'h0000, stat1_r} :
        (aofs == OFS_FLAG)   ? {31'h00000000, xf_r} :
        (aofs == OFS_WAIT)   ? {24'h000000, 1'b0, wait_io_r, 1'b0, wait_mem_r} :
        (aofs == OFS_AADDR)  ? {12'h000, aaddr_r} :
        (aofs == OFS_ACMD)   ? {28'h0000000, cmd_r.fetch, cmd_r.wr, cmd_r.space} :
        (aofs == OFS_STATUS) ? sts_word :
        (aofs == OFS_BRCFG)  ? {31'h00000000, xc_sel_r} :
                               32'h00000000;
    assign hrdata    = rdata_r;
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wvalid_r <= 1'b0;
            waddr_r  <= '0;
            rdata_r  <= '0;
        end else begin
            wvalid_r <= take && hwrite;
            waddr_r  <= aofs;
            if (take && !hwrite) begin
                rdata_r <= rd_mux;
            end
        end
    end

    // Mode bit: strap while the CPU is in reset, software afterwards
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rom_off_r <= 1'b0;
        end else if (!cpu_reset_n) begin
            rom_off_r <= rom_map_select;
        end else if (wr_mode) begin
            rom_off_r <= hwdata[MODE_ROM_OFF_BIT];
        end
    end

    // External flag: set high in reset, set/clear commands, status-one load clears
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xf_r    <= 1'b1;
            stat1_r <= STAT1_RST;
        end else if (!cpu_reset_n) begin
            xf_r    <= 1'b1;
            stat1_r <= STAT1_RST;
        end else begin
            if (wr_st1) begin
                stat1_r <= hwdata[STAT1_W-1:0];
                xf_r    <= 1'b0;
            end else if (wr_flag && hwdata[FLAG_SET_BIT]) begin
                xf_r <= 1'b1;
            end else if (wr_flag && hwdata[FLAG_CLR_BIT]) begin
                xf_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_mem_r <= '0;
            wait_io_r  <= '0;
            aaddr_r    <= AADDR_RST;
            xc_sel_r   <= 1'b0;
        end else begin
            if (wr_wait) begin
                wait_mem_r <= hwdata[WAIT_MEM_LSB +: WAIT_W];
                wait_io_r  <= hwdata[WAIT_IO_LSB +: WAIT_W];
            end
            if (wr_aadr) begin
                aaddr_r <= hwdata[ADDR_W-1:0];
            end
            if (wr_brcf) begin
                xc_sel_r <= hwdata[BRCFG_XC_BIT];
            end
        end
    end

    // Access command; a write while one is pending is ignored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_r  <= '0;
            pend_r <= 1'b0;
        end else if (!cpu_reset_n) begin
            pend_r <= 1'b0;
        end else if (wr_acmd) begin
            cmd_r.space <= deb_space_t'(hwdata[CMD_SPACE_LSB +: 2]);
            cmd_r.wr    <= hwdata[CMD_WR_BIT];
            cmd_r.fetch <= hwdata[CMD_FETCH_BIT];
            cmd_r.addr  <= aaddr_r;
            pend_r      <= 1'b1;
        end else if (start && !boot_pend_r) begin
            pend_r <= 1'b0;
        end
    end

    // Boot fetch armed by the CPU reset, issued once it is released
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_pend_r <= 1'b1;
        end else if (!cpu_reset_n) begin
            boot_pend_r <= 1'b1;
        end else if (start) begin
            boot_pend_r <= 1'b0;
        end
    end

    // Branch input captured in each pipeline phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cond_dec_r <= 1'b1;
            cond_rd_r  <= 1'b1;
        end else begin
            if (pipe_decode_stb) begin
                cond_dec_r <= branch_condition_input;
            end
            if (pipe_read_stb) begin
                cond_rd_r <= branch_condition_input;
            end
        end
    end

    // Sequencer; hold is only ever entered from idle, so hold never cuts a strobe (a CPU reset does)
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            S_IDLE: begin
                if (!hold_req_n) begin
                    st_nxt = S_HOLD;
                end else if (go) begin
                    st_nxt = S_STRB;
                end
            end
            S_STRB: begin
                if (!ext_r || (wtot_r == NO_WAIT)) begin
                    st_nxt = S_IDLE;
                end else begin
                    st_nxt = S_SWAIT;
                end
            end
            S_SWAIT: begin
                if (last_wait) begin
                    st_nxt = need_rdy ? S_RDY : S_IDLE;
                end
            end
            S_RDY: begin
                if (ready) begin
                    st_nxt = S_IDLE;
                end
            end
            S_HOLD: begin
                if (hold_req_n) begin
                    st_nxt = S_IDLE;
                end
            end
            default: begin
                st_nxt = S_IDLE;
            end
        endcase
        if (!cpu_reset_n && busy) begin
            st_nxt = S_IDLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r   <= S_IDLE;
            acc_r  <= '0;
            ext_r  <= 1'b0;
            wtot_r <= '0;
            widx_r <= '0;
        end else begin
            st_r <= st_nxt;
            if (start) begin
                acc_r  <= next_acc;
                ext_r  <= !rom_hit(next_acc, rom_off_r);
                wtot_r <= next_waits;
            end
            widx_r <= (st_nxt != S_SWAIT) ? NO_WAIT :
                      (st_r == S_STRB)    ? ONE_WAIT : widx_r + ONE_WAIT;
        end
    end

    // Pin levels
    assign pin_o.data_space_select_n    = !(active_ext && (acc_r.space == SP_DATA));
    assign pin_o.program_space_select_n = !(active_ext && (acc_r.space == SP_PROG));
    assign pin_o.io_space_select_n      = !(active_ext && (acc_r.space == SP_IO));
    assign pin_o.memory_strobe_n        = !(active_ext && (acc_r.space != SP_IO));
    assign pin_o.io_device_strobe_n     = !(active_ext && (acc_r.space == SP_IO));
    assign pin_o.rw                     = !(active_ext && acc_r.wr);
    assign pin_o.wait_state_done        = !msc_low;
    assign pin_o.instr_fetch_flag_n     = !(busy && acc_r.fetch);
    assign pin_o.external_flag_output   = xf_r;
    assign pin_o.bus_grant_ack          = in_hold;
    // Bus-control pins float in hold; everything floats with the float input low
    wire bus_oe = output_float_n && !in_hold;
    assign pin_oe.data_space_select_n    = bus_oe;
    assign pin_oe.program_space_select_n = bus_oe;
    assign pin_oe.io_space_select_n      = bus_oe;
    assign pin_oe.memory_strobe_n        = bus_oe;
    assign pin_oe.io_device_strobe_n     = bus_oe;
    assign pin_oe.rw                     = bus_oe;
    assign pin_oe.wait_state_done        = output_float_n;
    assign pin_oe.instr_fetch_flag_n     = output_float_n;
    assign pin_oe.external_flag_output   = output_float_n;
    assign pin_oe.bus_grant_ack          = output_float_n;
    // Upper address lines only carry program-space pages
    assign ext_addr    = (acc_r.space == SP_PROG) ? acc_r.addr
                       : {EXT_PAGE_0, acc_r.addr[LOW_ADDR_W-1:0]};
    assign ext_addr_oe = bus_oe;
    assign branch_taken         = !cond_sel;
    assign rom_in_program_space = !rom_off_r;

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_RESET_XF: assert property (!cpu_reset_n |=> xf_r)
        else $error("flag output not high under CPU reset");
    AST_STRAP: assert property (!cpu_reset_n |=> rom_off_r == $past(rom_map_select))
        else $error("mode strap not captured during CPU reset");
    AST_BOOT: assert property ($rose(cpu_reset_n) && st_r == S_IDLE && hold_req_n
                               |=> st_r == S_STRB && acc_r.addr == RESET_VECTOR
                                   && acc_r.fetch)
        else $error("boot fetch not at reset vector");
    AST_FLAG_SET: assert property (wr_flag && hwdata[FLAG_SET_BIT] && cpu_reset_n
                                   |=> xf_r)
        else $error("set command did not raise the flag");
    AST_ST1_CLR: assert property (wr_st1 && cpu_reset_n |=> !xf_r ##1
                                  (!xf_r || $past(wr_flag) || !$past(cpu_reset_n)))
        else $error("status-one load did not clear the flag");
    AST_FLOAT: assert property (!output_float_n |-> pin_oe == '0 && !ext_addr_oe)
        else $error("outputs driven while float input low");
    AST_HOLD_FLOAT: assert property (in_hold |-> pin_o.bus_grant_ack && !pin_oe.rw
                                     && !pin_oe.memory_strobe_n && !ext_addr_oe)
        else $error("bus control driven in hold");
    AST_GRANT_IDLE: assert property ($rose(in_hold) |-> $past(st_r) == S_IDLE
                                     && $past(pin_o.memory_strobe_n)
                                     && $past(pin_o.io_device_strobe_n))
        else $error("hold granted during an access");
    AST_READY_WAIT: assert property (st_r == S_RDY && !ready && cpu_reset_n
                                     |=> st_r == S_RDY && (!pin_o.memory_strobe_n
                                         || !pin_o.io_device_strobe_n))
        else $error("access ended while ready low");
    AST_NO_READY: assert property (st_r == S_SWAIT && last_wait && !need_rdy
                                   && cpu_reset_n |=> st_r == S_IDLE)
        else $error("ready sampled with fewer than two wait states");
    AST_MSC_EDGES: assert property (st_r == S_STRB && ext_r && need_rdy && cpu_reset_n
                                    |=> !pin_o.wait_state_done ##[1:6]
                                        (pin_o.wait_state_done && st_r == S_SWAIT
                                         && last_wait))
        else $error("wait done edges misplaced");
    AST_RW: assert property (!pin_o.rw |-> active_ext && acc_r.wr)
        else $error("write level outside an external write");
    AST_STROBE_SEL: assert property (!pin_o.memory_strobe_n
                                     |-> pin_o.data_space_select_n
                                         != pin_o.program_space_select_n)
        else $error("memory strobe without a memory space select");
    AST_ROM_INT: assert property (busy && !ext_r |-> pin_o.memory_strobe_n
                                  && pin_o.program_space_select_n)
        else $error("internal ROM access reached the pins");
    AST_UPPER: assert property (ext_addr[ADDR_W-1:LOW_ADDR_W] != EXT_PAGE_0
                                |-> acc_r.space == SP_PROG)
        else $error("upper address lines used outside program space");
    AST_FETCH: assert property (!pin_o.instr_fetch_flag_n |-> busy && acc_r.fetch)
        else $error("fetch flag low without a fetch");

endmodule

// File: tb/deb_far_model.sv
// Far-side memory and I/O model that answers ready, looped or late
`timescale 1ns/10ps
module deb_far_model
    import deb_pkg::*;
(
    // Clock and control pins
    input  wire logic      hclk,
    input  wire deb_pins_t pin_o,
    input  wire logic      loop,
    // Answer
    output logic           ready
);
    int cnt = 0;
    wire idle = pin_o.memory_strobe_n & pin_o.io_device_strobe_n;
    always @(posedge hclk) cnt <= idle ? 0 : cnt + 1;
    // A slow device holds ready low for the first four access cycles
    assign ready = loop ? pin_o.wait_state_done : (cnt >= 4);
endmodule

// File: tb/deb_ext_bus_ctrl_bench.sv
// Self-checking bench of the external bus controller
`timescale 1ns/10ps
module deb_ext_bus_ctrl_bench
    import deb_pkg::*;
;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, lp = 0, cr_n = 0;
    logic        bci = 1, hr_n = 1, of_n = 1, dstb = 0, rstb = 0, rms = 0;
    logic        hreadyout, hresp, ready, taken, rom_in, aoe;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, lf = 32'h64ab6a1f;
    logic [1:0]  htrans = 0;
    logic [3:0]  c, lt = 4'b1001, ct[4] = '{4'h4, 4'h9, 4'h0, 4'h6};
    logic [ADDR_W-1:0] ext_addr, a;
    deb_pins_t   pin_o, pin_oe;
    int          failures = 0, cmp_count = 0, cyc = 0, n, e, ns, nsel, nw, nf, nd;
    int          nt[4] = '{2, 3, 2, 1};

    deb_ext_bus_ctrl #(.WAIT_W(3)) deb_ext_bus_ctrl_i (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .cpu_reset_n(cr_n), .rom_map_select(rms),
        .branch_condition_input(bci), .ready(ready), .hold_req_n(hr_n),
        .output_float_n(of_n), .pipe_decode_stb(dstb), .pipe_read_stb(rstb),
        .pin_o(pin_o), .pin_oe(pin_oe), .ext_addr(ext_addr), .ext_addr_oe(aoe),
        .branch_taken(taken), .rom_in_program_space(rom_in));
    deb_far_model deb_far_model_i (.hclk(hclk), .pin_o(pin_o), .loop(lp), .ready(ready));

    always #2.5 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            print_verdict();
        end
    end

    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x) begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, g, x);
        end
    endtask

    // Address phase held until hready, then data phase held until hready
    task automatic bus(input logic [7:0] ad, input logic w, input logic [31:0] d);
        hsel <= 1; haddr <= {24'h0, ad}; hwrite <= w; htrans <= 2'h2;
        @(posedge hclk); while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0; hwdata <= d;
        @(posedge hclk); while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic print_verdict();
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1; cr_n <= 1;
        repeat (12) @(posedge hclk);
        chk(pin_o.external_flag_output, 1'b1);
        chk(rom_in, 1'b1);
        bus(OFS_STATUS, 0, 0); chk(rd[STS_BOOT_BIT], 1'b0);
        bus(8'h20, 0, 0); chk(rd, 32'h0); chk(hresp, HRESP_OKAY);
        $display("test reset done");
        bus(OFS_FLAG, 1, 32'h2); bus(OFS_FLAG, 0, 0); chk(rd[0], 1'b0);
        bus(OFS_FLAG, 1, 32'h3); bus(OFS_FLAG, 0, 0); chk(rd[0], 1'b1);
        lf = nx(lf);
        bus(OFS_STAT1, 1, lf); bus(OFS_STAT1, 0, 0); chk(rd, {16'h0, lf[15:0]});
        bus(OFS_FLAG, 0, 0); chk(rd[0], 1'b0);
        $display("test flag done");
        for (int k = 0; k < 4; k++) begin
            lf = nx(lf); a = {4'h1, lf[15:0]}; n = nt[k]; c = ct[k]; lp <= lt[k];
            bus(OFS_WAIT, 1, c[1] ? n << 4 : n); bus(OFS_AADDR, 1, a); bus(OFS_ACMD, 1, c);
            ns = 0; nsel = 0; nw = 0; nf = 0; nd = 0;
            repeat (20) begin
                @(negedge hclk);
                ns += (c[1] ? pin_o.io_device_strobe_n : pin_o.memory_strobe_n) === 1'b0;
                nsel += pin_o[9 - c[1:0]] === 1'b0;
                nw += pin_o.rw === 1'b0;
                nf += pin_o.instr_fetch_flag_n === 1'b0;
                nd += pin_o.wait_state_done === 1'b0;
            end
            @(posedge hclk);
            e = 1 + n + (n < 2 ? 0 : lt[k] ? 1 : (4 - n > 1 ? 4 - n : 1));
            chk(ns, e);
            chk(nsel, e);
            chk(nw, c[2] ? e : 0);
            chk(nf, c[3] ? e : 0);
            chk(nd, n >= 2 ? n - 1 : 0);
            chk(ext_addr, c[1:0] == SP_PROG ? a : {4'h0, a[15:0]});
        end
        $display("test access done");
        hr_n <= 0; repeat (4) @(posedge hclk);
        chk(pin_o.bus_grant_ack, 1'b1);
        chk({pin_oe.memory_strobe_n, pin_oe.rw, aoe}, 3'h0);
        bus(OFS_ACMD, 1, 32'h0); bus(OFS_STATUS, 0, 0); chk(rd[STS_PEND_BIT], 1'b1);
        hr_n <= 1; repeat (20) @(posedge hclk);
        bus(OFS_STATUS, 0, 0); chk(rd[STS_PEND_BIT:STS_HOLD_BIT], 6'h04);
        of_n <= 0; repeat (2) @(posedge hclk); chk(pin_oe, 10'h0); of_n <= 1;
        $display("test hold and float done");
        for (int v = 0; v < 3; v++) begin
            if (v == 2) bus(OFS_BRCFG, 1, 32'h1);
            bci <= v[0] ^ v[1]; rstb <= 1; @(posedge hclk); rstb <= 0;
            repeat (2) @(posedge hclk); chk(taken, v == 0);
        end
        bci <= 0; dstb <= 1; @(posedge hclk); dstb <= 0; bci <= 1;
        repeat (2) @(posedge hclk); chk(taken, 1'b1);
        $display("test branch done");
        rms <= 1; cr_n <= 0; repeat (2) @(posedge hclk);
        chk(pin_o.external_flag_output, 1'b1);
        cr_n <= 1; repeat (12) @(posedge hclk);
        rms <= 0; chk(rom_in, 1'b0);
        bus(OFS_STATUS, 0, 0); chk(rd[STS_BOOT_BIT], 1'b0);
        bus(OFS_MODE, 1, 0); bus(OFS_MODE, 0, 0); chk(rd[0], 1'b0);
        chk(rom_in, 1'b1);
        $display("test cpu reset done");
        print_verdict();
    end
endmodule
